//--- design/crp_pkg.sv
package crp_pkg;
  // key table
  localparam int KEY_DEPTH = 32;
  localparam int KEY_IDX_W = 5;
  localparam logic [4:0] KEY_IDX_RESET = 5'h00;
  localparam logic [4:0] KEY_IDX_LAST = 5'h1f;
  localparam logic [7:0] KEY_ERASED = 8'hff;
  // mask-coded layout
  localparam logic [12:0] MASK_USER_LAST = 13'h0fff;
  localparam logic [12:0] MASK_KEY_BASE = 13'h1000;
  localparam logic [12:0] MASK_KEY_LAST = 13'h101f;
  localparam logic [12:0] MASK_LOCK_ADDR = 13'h1020;
  localparam int LOCK1_BIT = 0;
  localparam int LOCK2_BIT = 1;
  localparam logic [11:0] CODE_ADDR_RESET = 12'h000;
  localparam logic [7:0] DATA_RESET = 8'h00;

  typedef enum logic [1:0] {
    CRP_TGT_CODE,
    CRP_TGT_KEY,
    CRP_TGT_LOCK1,
    CRP_TGT_LOCK2
  } crp_target_t;

  typedef enum {
    CRP_IDLE,
    CRP_BUSY
  } crp_state_t;
endpackage

//--- design/crp_key_if.sv
`timescale 1ns/1ps
interface crp_key_if;
  logic [4:0] wrIdx;
  logic [7:0] wrData;
  logic       wrEn;
  logic [4:0] rdIdx;
  logic [7:0] rdKey;
  modport owner (input wrIdx, input wrData, input wrEn, input rdIdx, output rdKey);
  modport user (output wrIdx, output wrData, output wrEn, output rdIdx, input rdKey);
endinterface

//--- design/crp_key_table.sv
`timescale 1ns/1ps
module crp_key_table
  import crp_pkg::*;
(
  // clock and reset
  input wire logic sysClk,
  input wire logic resetn,
  // table access
  crp_key_if.owner keyBus
);
  import crp_pkg::*;

  logic [7:0] keyMem [KEY_DEPTH];

  // erased table is all ones, which passes data unchanged
  genvar g;
  generate
    for (g = 0; g < KEY_DEPTH; g++)
    begin : gKey
      always_ff @(posedge sysClk)
      begin
        if (!resetn)
          keyMem[g] <= KEY_ERASED;
        else if (keyBus.wrEn && keyBus.wrIdx == 5'(g))
          keyMem[g] <= keyBus.wrData;
      end
    end
  endgenerate

  assign keyBus.rdKey = keyMem[keyBus.rdIdx];
endmodule

//--- design/code_readout_protection.sv
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - a 32-byte key is XNORed with each program byte read out by verify; table reads return the raw byte
// - key bytes apply in read order, first read uses first entry
// - the key table has no external read path
// - after key programming, verify reads return only keyed data
// - two independent one-time lock bits restrict readout and programming
// - lock one blocks the code table read instruction from outside
// - lock one refuses further programming of code array and key table
// - lock one never blocks programming of lock two
// - with only lock one set, verify readout still works
// - lock two blocks all verify readout
// - mask parts take key from 1000H-101FH; FFH means no keying
// - mask parts take locks from bits 0,1 of 1020H; 0 enables
module code_readout_protection
  import crp_pkg::*;
(
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             resetn,
  // variant: high for mask-coded part
  input  wire logic             maskCoded,
  // programmer write request
  input  wire logic             progReq,
  input  wire crp_pkg::crp_target_t progTarget,
  input  wire logic [11:0]      progAddr,
  input  wire logic [7:0]       progData,
  // verifier read request
  input  wire logic             verifyReq,
  input  wire logic [11:0]      verifyAddr,
  // external code table read instruction
  input  wire logic             tableReadReq,
  input  wire logic [11:0]      tableReadAddr,
  // mask image port
  output logic [12:0]           maskAddr,
  input  wire logic [7:0]       maskData,
  // answers
  output logic                  progDone,
  output logic                  progRefused,
  output logic                  verifyValid,
  output logic [7:0]            verifyData,
  output logic                  verifyRefused,
  output logic                  tableReadValid,
  output logic [7:0]            tableReadData,
  output logic                  tableReadRefused,
  // lock state
  output logic                  lock1Set,
  output logic                  lock2Set,
  output logic                  maskLoaded
);
  import crp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // storage
  logic [7:0]  codeMem [4096];
  logic        lock1_reg;
  logic        lock2_reg;
  logic        lock1_next;
  logic        lock2_next;
  logic [4:0]  keyIdx_reg;
  logic [4:0]  keyIdx_next;
  logic [12:0] loadPtr_reg;
  logic        loaded_reg;
  crp_state_t  state_reg;

  crp_key_if keyBus ();

  crp_key_table uKeyTable
  (
    .sysClk (sys_clk),
    .resetn (resetn),
    .keyBus (keyBus)
  );

  ////////////////////////////////////////////////////////////////////////////
  // decode
  function automatic logic inRange(input logic [12:0] a, input logic [12:0] lo, input logic [12:0] hi);
    inRange = (a >= lo) && (a <= hi);
  endfunction

  wire         loading    = maskCoded && !loaded_reg;
  wire         ldUser     = loading && inRange(loadPtr_reg, 13'h0000, MASK_USER_LAST);
  wire         ldKey      = loading && inRange(loadPtr_reg, MASK_KEY_BASE, MASK_KEY_LAST);
  wire         ldLock     = loading && (loadPtr_reg == MASK_LOCK_ADDR);
  wire         ready      = !loading && (state_reg == CRP_IDLE);
  wire         progOk     = ready && progReq && !maskCoded;
  wire         lockTarget = (progTarget == CRP_TGT_LOCK1) || (progTarget == CRP_TGT_LOCK2);
  wire         progAllow  = progOk && (!lock1_reg || lockTarget);
  wire         progDeny   = progOk && !progAllow;
  wire         verOk      = ready && verifyReq && !progReq;
  wire         verAllow   = verOk && !lock2_reg;
  wire         tblOk      = ready && tableReadReq && !progReq && !verifyReq;
  wire         tblAllow   = tblOk && !lock1_reg;
  wire [7:0]   keyedByte  = ~(codeMem[verifyAddr] ^ keyBus.rdKey);

  // read order selector, wraps to KEY_IDX_RESET after KEY_IDX_LAST
  assign keyIdx_next = (keyIdx_reg == KEY_IDX_LAST) ? KEY_IDX_RESET : keyIdx_reg + 5'h01;

  // one-time locks: only ever set
  assign lock1_next = lock1_reg
                    | (progAllow && progTarget == CRP_TGT_LOCK1)
                    | (ldLock && !maskData[LOCK1_BIT]);
  assign lock2_next = lock2_reg
                    | (progAllow && progTarget == CRP_TGT_LOCK2)
                    | (ldLock && !maskData[LOCK2_BIT]);

  // key table write path; no read path leaves the block except keyed data
  assign keyBus.wrEn   = (progAllow && progTarget == CRP_TGT_KEY) || ldKey;
  assign keyBus.wrIdx  = ldKey ? loadPtr_reg[4:0] : progAddr[4:0];
  assign keyBus.wrData = ldKey ? maskData : progData;
  assign keyBus.rdIdx  = keyIdx_reg;

  ////////////////////////////////////////////////////////////////////////////
  // mask image load sequencer
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      loadPtr_reg <= 13'h0000;
      loaded_reg  <= 1'b0;
    end
    else if (loading)
    begin
      loadPtr_reg <= loadPtr_reg + 13'h0001;
      loaded_reg  <= (loadPtr_reg == MASK_LOCK_ADDR);
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      maskAddr <= 13'h0000;
    else
      maskAddr <= loading ? loadPtr_reg + 13'h0001 : 13'h0000;
  end

  ////////////////////////////////////////////////////////////////////////////
  // code array
  always_ff @(posedge sys_clk)
  begin
    if (ldUser)
      codeMem[loadPtr_reg[11:0]] <= maskData;
    else if (progAllow && progTarget == CRP_TGT_CODE)
      codeMem[progAddr] <= progData;
  end

  ////////////////////////////////////////////////////////////////////////////
  // state and answers
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      state_reg  <= CRP_IDLE;
      lock1_reg  <= 1'b0;
      lock2_reg  <= 1'b0;
      keyIdx_reg <= KEY_IDX_RESET;
    end
    else
    begin
      lock1_reg <= lock1_next;
      lock2_reg <= lock2_next;
      if (verAllow)
        keyIdx_reg <= keyIdx_next;
      case (state_reg)
        CRP_IDLE: state_reg <= (progOk || verOk || tblOk) ? CRP_BUSY : CRP_IDLE;
        CRP_BUSY: state_reg <= CRP_IDLE;
        default:  state_reg <= CRP_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      progDone         <= 1'b0;
      progRefused      <= 1'b0;
      verifyValid      <= 1'b0;
      verifyData       <= DATA_RESET;
      verifyRefused    <= 1'b0;
      tableReadValid   <= 1'b0;
      tableReadData    <= DATA_RESET;
      tableReadRefused <= 1'b0;
      lock1Set         <= 1'b0;
      lock2Set         <= 1'b0;
      maskLoaded       <= 1'b0;
    end
    else
    begin
      progDone         <= progAllow;
      progRefused      <= progDeny;
      verifyValid      <= verAllow;
      verifyData       <= verAllow ? keyedByte : DATA_RESET;
      verifyRefused    <= verOk && lock2_reg;
      tableReadValid   <= tblAllow;
      tableReadData    <= tblAllow ? codeMem[tableReadAddr] : DATA_RESET;
      tableReadRefused <= tblOk && lock1_reg;
      lock1Set         <= lock1_next;
      lock2Set         <= lock2_next;
      maskLoaded       <= loaded_reg;
    end
  end
endmodule

//--- bench/crp_monitor.sv
`timescale 1ns/1ps
module crp_monitor
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // requests and answers
  input wire logic verifyReq,
  input wire logic progRefused,
  input wire logic verifyValid,
  input wire logic verifyRefused,
  input wire logic tableReadValid,
  input wire logic tableReadRefused,
  input wire logic lock1Set,
  input wire logic lock2Set
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  AST_VFY_PULSE: assert property (verifyValid |=> !verifyValid) else $error("verify pulse long");
  AST_VFY_CAUSE: assert property (verifyValid |-> $past(verifyReq)) else $error("verify no cause");
  AST_VFY_LOCK: assert property (verifyValid |-> !$past(lock2Set)) else $error("verify under lock");
  AST_VFY_REF: assert property (verifyRefused |-> $past(lock2Set)) else $error("verify refused");
  AST_TBL_LOCK: assert property (tableReadValid |-> !$past(lock1Set)) else $error("table read");
  AST_TBL_REF: assert property (tableReadRefused |-> $past(lock1Set)) else $error("table refused");
  AST_PROG_REF: assert property (progRefused |-> $past(lock1Set)) else $error("prog refused");
  AST_LOCK1_KEEP: assert property (lock1Set |=> lock1Set) else $error("lock one lost");
  AST_LOCK2_KEEP: assert property (lock2Set |=> lock2Set) else $error("lock two lost");
endmodule
bind code_readout_protection crp_monitor crp_monitor_inst (.*);

//--- bench/crp_mask_image.sv
`timescale 1ns/1ps
module crp_mask_image
  import crp_pkg::*;
(
  // mask image port
  input  wire logic [12:0] maskAddr,
  output logic [7:0]       maskData
);
  // code byte, key byte, lock byte with lock one enabled
  assign maskData = (maskAddr <= MASK_USER_LAST) ? (maskAddr[7:0] ^ 8'h5a) :
                    (maskAddr <= MASK_KEY_LAST) ? {3'h0, maskAddr[4:0]} :
                    (maskAddr == MASK_LOCK_ADDR) ? 8'hfe : 8'hff;
endmodule

//--- bench/code_readout_protection_tb_top.sv
`timescale 1ns/1ps
module code_readout_protection_tb_top;
  import crp_pkg::*;
  logic        sys_clk, resetn, maskCoded, progReq, verifyReq, tableReadReq;
  crp_target_t progTarget;
  logic [11:0] progAddr, verifyAddr, tableReadAddr;
  logic [7:0]  progData, maskData, verifyData, tableReadData;
  logic [12:0] maskAddr;
  logic        progDone, progRefused, verifyValid, verifyRefused, tableReadValid, tableReadRefused;
  logic        lock1Set, lock2Set, maskLoaded;
  logic [7:0]  key [32];
  int          errTotal, samplesChecked, cyc, vIdx;
  code_readout_protection code_readout_protection_inst (.*);
  crp_mask_image crp_mask_image_inst (.*);
  always #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      errTotal++;
      summarize();
    end
  end
  //////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d errors %0d", samplesChecked, errTotal);
    if (errTotal == 0 && samplesChecked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    samplesChecked++;
    if (g !== e)
    begin
      errTotal++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic rst(input logic m);
    @(negedge sys_clk);
    resetn = 1'h0;
    maskCoded = m;
    vIdx = 0;
    for (int i = 0; i < 32; i++)
      key[i] = KEY_ERASED;
    repeat (4) @(negedge sys_clk);
    resetn = 1'h1;
  endtask
  // k: 0 write, 1 verify, 2 table read; flags {pd,pr,vv,vr,tv,tr}
  task automatic xfer(input int k, input logic [11:0] a, input logic [7:0] d, input crp_target_t t,
                      input logic [7:0] ef, input logic [7:0] ed);
    @(negedge sys_clk);
    progTarget = t;
    progAddr = a;
    progData = d;
    verifyAddr = a;
    tableReadAddr = a;
    progReq = (k == 0);
    verifyReq = (k == 1);
    tableReadReq = (k == 2);
    @(negedge sys_clk);
    chk({2'h0, progDone, progRefused, verifyValid, verifyRefused, tableReadValid, tableReadRefused}, ef);
    chk(verifyData | tableReadData, ed);
    progReq = 1'h0;
    verifyReq = 1'h0;
    tableReadReq = 1'h0;
  endtask
  task automatic vfy(input logic [11:0] a, input logic [7:0] c);
    xfer(1, a, 8'h00, CRP_TGT_CODE, 8'h08, ~(c ^ key[vIdx]));
    vIdx = (vIdx + 1) % 32;
  endtask
  task automatic sc_erased();
    for (int i = 0; i < 4; i++)
      xfer(0, 12'(i), 8'(8'h30 + i), CRP_TGT_CODE, 8'h20, 8'h00);
    for (int i = 0; i < 4; i++)
      vfy(12'(i), 8'(8'h30 + i));
    xfer(2, 12'h002, 8'h00, CRP_TGT_CODE, 8'h02, 8'h32);
  endtask
  task automatic sc_keyed();
    for (int i = 0; i < 32; i++)
    begin
      key[i] = 8'(i * 37);
      xfer(0, 12'(i), key[i], CRP_TGT_KEY, 8'h20, 8'h00);
    end
    for (int i = 0; i < 34; i++)
      vfy(12'(i % 4), 8'(8'h30 + i % 4));
  endtask
  task automatic sc_locks();
    xfer(0, 12'h000, 8'h00, CRP_TGT_LOCK1, 8'h20, 8'h00);
    chk({6'h00, lock2Set, lock1Set}, 8'h01);
    xfer(0, 12'h001, 8'h55, CRP_TGT_CODE, 8'h10, 8'h00);
    xfer(0, 12'h001, 8'h55, CRP_TGT_KEY, 8'h10, 8'h00);
    xfer(2, 12'h001, 8'h00, CRP_TGT_CODE, 8'h01, 8'h00);
    vfy(12'h001, 8'h31);
    xfer(0, 12'h000, 8'h00, CRP_TGT_LOCK2, 8'h20, 8'h00);
    xfer(1, 12'h001, 8'h00, CRP_TGT_CODE, 8'h04, 8'h00);
  endtask
  task automatic sc_mask();
    rst(1'h1);
    for (int i = 0; i < 32; i++)
      key[i] = 8'(i);
    for (int i = 0; i < 5000 && maskLoaded !== 1'h1; i++)
      @(negedge sys_clk);
    chk({6'h00, lock2Set, lock1Set}, 8'h01);
    vfy(12'h005, 8'h5f);
    vfy(12'hfff, 8'ha5);
    xfer(2, 12'h005, 8'h00, CRP_TGT_CODE, 8'h01, 8'h00);
    xfer(0, 12'h005, 8'h00, CRP_TGT_CODE, 8'h00, 8'h00);
  endtask
  initial
  begin
    sys_clk = 1'h0;
    resetn = 1'h0;
    maskCoded = 1'h0;
    {progReq, verifyReq, tableReadReq} = 3'h0;
    progTarget = CRP_TGT_CODE;
    {progAddr, verifyAddr, tableReadAddr, progData} = 44'h0;
    rst(1'h0);
    sc_erased();
    sc_keyed();
    sc_locks();
    sc_mask();
    summarize();
  end
endmodule
